// >>> hw/lcddc_core.sv
// lcd driver control core with ahb-lite register slave
`timescale 1ns/1ns
`default_nettype none
// Operation
// RL1 - control bit 7 selects the lcd driver at 0 and the led driver at 1, never both.
// RL2 - control bit 6 disables the lcd driver at 0 and enables it at 1.
// RL3 - control bit 5 makes the drive level follow contrast_level, else full supply.
// RL4 - control bit 4 picks four backplanes at 1/3 bias or eight at 1/4 bias.
// RL5 - contrast_level picks a rising drive level, with 1110 and 1111 both full supply.
// RL6 - bias_drive_scheme picks high sum, 60K sum, or fast charge switching between them.
// RL7 - fast charge low sum lasts 1/8, 1/16, 1/32 or 1/64 of the backplane period.
// RL8 - bias_resistor_select picks the 225K network at 0 and the 900K network at 1.
// RL9 - the nine-bit divider passes the oscillator at zero and divides by its value otherwise.
// RL10 - one frame lasts 512 display clock periods.
// RL11 - the divider only acts for oscillator options 0000 and 1110.
// RL12 - each port0_segment_enable bit turns its pin into frontplane 17, 18 or 19.
// RL13 - any reset turns the lcd off and drives every backplane and frontplane low.
// RL14 - power-down stops the lcd unless a low-frequency clock runs; memory is kept.
// RL15 - segment patterns come from a 19-byte memory at 1e0h-1f2h, also usable as data.
// RL16 - backplanes take equal slots in turn, each showing its bit of every byte.
// RL17 - with the lcd disabled or the led selected all lcd lines stay low.
module lcddc_core (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [3:0] oscillator_option,
  input wire logic power_down,
  input wire logic low_freq_clock_run,
  output logic [7:0] backplane,
  output logic [18:0] frontplane_line,
  output logic lcd_active,
  output logic led_driver_select,
  output logic [3:0] lcd_drive_voltage,
  output logic bias_low_sum,
  output logic bias_high_900k,
  output logic [2:0] port0_segment_enable
);
  // bus slave state
  lcddc_pkg::lcddc_bus_e bus_q, bus_d;
  logic [9:0] idx_q, idx_d;
  logic wr_q, wr_d;
  logic [31:0] rdata_q, rdata_d;
  // software-visible registers
  lcddc_pkg::lcddc_ctrl_s ctrl_q, ctrl_d;
  lcddc_pkg::lcddc_drive_s drv_q, drv_d;
  logic [8:0] div_q, div_d;
  logic [2:0] p0s_q, p0s_d;
  logic [7:0] mem_q [lcddc_pkg::MEM_BYTES];
  logic [7:0] mem_d [lcddc_pkg::MEM_BYTES];
  // timing state
  logic [3:0] osc_meta_q, osc_q;
  logic [8:0] divcnt_q, divcnt_d;
  logic [8:0] frame_q, frame_d;
  // output flops
  logic [7:0] bp_q, bp_d;
  logic [18:0] fp_q, fp_d;
  logic on_q, on_d;
  logic [3:0] vlcd_q, vlcd_d;
  logic blow_q, blow_d;
  logic b900_q, b900_d;
  // combinational helpers
  logic accept, div_ok, use_div, tick, disp_on, fast_low;
  logic [2:0] slot;
  logic [7:0] pos, slot_len, fc_len;
  logic [4:0] mem_off;
  logic in_mem;
  logic [18:0] seg_gate;

  assign accept = hsel && hready && htrans[1];
  assign hreadyout = (bus_q != lcddc_pkg::LCDDC_BUS_WAIT);
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign in_mem = (idx_q >= lcddc_pkg::IDX_MEM_FIRST) && (idx_q <= lcddc_pkg::IDX_MEM_LAST);
  assign mem_off = 5'(idx_q - lcddc_pkg::IDX_MEM_FIRST);

  // bus: address phase taken, one wait cycle, then response
  always_comb begin
    bus_d = bus_q;
    idx_d = idx_q;
    wr_d = wr_q;
    case (bus_q)
      lcddc_pkg::LCDDC_BUS_IDLE,
      lcddc_pkg::LCDDC_BUS_RESP: begin
        if (accept) begin
          bus_d = lcddc_pkg::LCDDC_BUS_WAIT;
          idx_d = haddr[11:2];
          wr_d = hwrite;
        end else begin
          bus_d = lcddc_pkg::LCDDC_BUS_IDLE;
        end
      end
      lcddc_pkg::LCDDC_BUS_WAIT: bus_d = lcddc_pkg::LCDDC_BUS_RESP;
      default: bus_d = lcddc_pkg::LCDDC_BUS_IDLE;
    endcase
  end

  // register writes and read data, both in the wait cycle
  always_comb begin
    ctrl_d = ctrl_q;
    drv_d = drv_q;
    div_d = div_q;
    p0s_d = p0s_q;
    mem_d = mem_q;
    rdata_d = rdata_q;
    if (bus_q == lcddc_pkg::LCDDC_BUS_WAIT) begin
      rdata_d = 32'h0000_0000;
      if (wr_q) begin
        case (idx_q)
          lcddc_pkg::IDX_DIV_HIGH: div_d[8] = hwdata[0];
          lcddc_pkg::IDX_CONTROL: ctrl_d = hwdata[7:0];
          lcddc_pkg::IDX_DIV_LOW: div_d[7:0] = hwdata[7:0];
          lcddc_pkg::IDX_DRIVE: drv_d = lcddc_pkg::lcddc_drive_s'(hwdata[4:0]);
          lcddc_pkg::IDX_PORT0_SEL: p0s_d = hwdata[2:0];
          default: if (in_mem) mem_d[mem_off] = hwdata[7:0]; // RL15
        endcase
      end else begin
        case (idx_q)
          lcddc_pkg::IDX_DIV_HIGH: rdata_d = {31'h0, div_q[8]};
          lcddc_pkg::IDX_CONTROL: rdata_d = {24'h0, ctrl_q};
          lcddc_pkg::IDX_DIV_LOW: rdata_d = {24'h0, div_q[7:0]};
          lcddc_pkg::IDX_DRIVE: rdata_d = {27'h0, drv_q};
          lcddc_pkg::IDX_PORT0_SEL: rdata_d = {29'h0, p0s_q};
          default: if (in_mem) rdata_d = {24'h0, mem_q[mem_off]};
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_q <= lcddc_pkg::LCDDC_BUS_IDLE;
      idx_q <= 10'h000;
      wr_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      ctrl_q <= lcddc_pkg::RST_CONTROL;
      drv_q <= lcddc_pkg::lcddc_drive_s'(lcddc_pkg::RST_DRIVE);
      div_q <= lcddc_pkg::RST_DIVIDER;
      p0s_q <= lcddc_pkg::RST_PORT0;
    end else begin
      bus_q <= bus_d;
      idx_q <= idx_d;
      wr_q <= wr_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      drv_q <= drv_d;
      div_q <= div_d;
      p0s_q <= p0s_d;
    end
  end

  // display memory keeps contents across power-down and reset
  always_ff @(posedge clk) begin
    mem_q <= mem_d; // RL14
  end

  // code option strap, two-flop synchroniser
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      osc_meta_q <= 4'h0;
      osc_q <= 4'h0;
    end else begin
      osc_meta_q <= oscillator_option;
      osc_q <= osc_meta_q;
    end
  end

  // display clock divider
  assign div_ok = (osc_q == lcddc_pkg::OSC_INTERNAL_RC) || (osc_q == lcddc_pkg::OSC_CRYSTAL); // RL11
  assign use_div = div_ok && (div_q != 9'h000); // RL9
  // at or past the end, so a shrunk divider never waits for a counter wrap
  assign tick = !use_div || (divcnt_q >= 9'(div_q - 9'h001)); // RL9

  // lcd runs only when selected, enabled and clocked
  assign disp_on = !ctrl_q.type_sel && ctrl_q.lcd_en && (!power_down || low_freq_clock_run); // RL1 RL2 RL14

  // slot and position inside the backplane period
  assign slot = ctrl_q.duty8 ? frame_q[8:6] : {1'b0, frame_q[8:7]}; // RL4 RL16
  assign pos = ctrl_q.duty8 ? {2'b00, frame_q[5:0]} : {1'b0, frame_q[6:0]};
  assign slot_len = ctrl_q.duty8 ? lcddc_pkg::SLOT_TICKS_EIGHTH : lcddc_pkg::SLOT_TICKS_QUARTER;
  assign fc_len = slot_len >> ({1'b0, lcddc_pkg::FCT_BASE_SHIFT} + {1'b0, drv_q.fct}); // RL7
  assign fast_low = (drv_q.scheme == lcddc_pkg::LCDDC_FAST) && (pos < fc_len); // RL7
  assign seg_gate = {p0s_q, 16'hffff}; // RL12

  always_comb begin
    divcnt_d = tick ? 9'h000 : 9'(divcnt_q + 9'h001);
    frame_d = frame_q;
    if (!disp_on) begin
      frame_d = 9'h000;
    end else if (tick) begin
      frame_d = 9'(frame_q + 9'h001); // RL10
    end
  end

  always_comb begin
    bp_d = 8'h00; // RL17
    fp_d = 19'h00000; // RL17
    on_d = disp_on;
    if (disp_on) begin
      bp_d = 8'(8'h01 << slot); // RL16
      for (int i = 0; i < lcddc_pkg::MEM_BYTES; i++) begin
        fp_d[i] = mem_q[i][slot] && seg_gate[i]; // RL15 RL16 RL12
      end
    end
    if (ctrl_q.contrast_en) begin
      vlcd_d = (ctrl_q.level == lcddc_pkg::LEVEL_ALIAS_FULL) ? lcddc_pkg::LEVEL_FULL
               : ctrl_q.level; // RL5
    end else begin
      vlcd_d = lcddc_pkg::LEVEL_FULL; // RL3
    end
    case (drv_q.scheme)
      lcddc_pkg::LCDDC_TRAD_LOW: blow_d = 1'b1; // RL6
      lcddc_pkg::LCDDC_FAST: blow_d = fast_low; // RL6
      default: blow_d = 1'b0; // RL6
    endcase
    b900_d = drv_q.rsel; // RL8
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      divcnt_q <= 9'h000;
      frame_q <= 9'h000;
      bp_q <= 8'h00; // RL13
      fp_q <= 19'h00000; // RL13
      on_q <= 1'b0; // RL13
      vlcd_q <= lcddc_pkg::LEVEL_FULL;
      blow_q <= 1'b0;
      b900_q <= 1'b0;
    end else begin
      divcnt_q <= divcnt_d;
      frame_q <= frame_d;
      bp_q <= bp_d;
      fp_q <= fp_d;
      on_q <= on_d;
      vlcd_q <= vlcd_d;
      blow_q <= blow_d;
      b900_q <= b900_d;
    end
  end

  assign backplane = bp_q;
  assign frontplane_line = fp_q;
  assign lcd_active = on_q;
  assign led_driver_select = ctrl_q.type_sel; // RL1
  assign lcd_drive_voltage = vlcd_q;
  assign bias_low_sum = blow_q;
  assign bias_high_900k = b900_q;
  assign port0_segment_enable = p0s_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_wait_then_resp;
    !hreadyout ##1 hreadyout;
  endsequence

  chk_bus_one_wait: assert property (accept && hreadyout |=> s_wait_then_resp)
    else $error("bus answer not after exactly one wait cycle");
  chk_led_blanks: assert property (ctrl_q.type_sel |=> bp_q == 8'h00 && fp_q == 19'h00000) // RL1
    else $error("lcd lines active while led selected");
  chk_enable_off: assert property (!ctrl_q.lcd_en |=> !on_q && bp_q == 8'h00) // RL2
    else $error("lcd lines active while lcd disabled");
  chk_contrast_off: assert property (!ctrl_q.contrast_en |=> vlcd_q == 4'hf) // RL3
    else $error("drive level not full with contrast off");
  chk_quarter_duty: assert property (disp_on && !ctrl_q.duty8 |=> bp_q[7:4] == 4'h0) // RL4
    else $error("upper backplanes active at quarter duty");
  chk_level_alias: assert property (ctrl_q.contrast_en && ctrl_q.level == 4'he // RL5
    |=> vlcd_q == 4'hf)
    else $error("code 1110 not full supply");
  chk_scheme_low: assert property (drv_q.scheme == lcddc_pkg::LCDDC_TRAD_LOW |=> blow_q) // RL6
    else $error("60K sum not selected");
  chk_fast_start: assert property (drv_q.scheme == lcddc_pkg::LCDDC_FAST && pos == 8'h00 // RL7
    |=> blow_q)
    else $error("fast charge missing at slot start");
  chk_fast_end: assert property (drv_q.scheme == lcddc_pkg::LCDDC_FAST && pos == fc_len // RL7
    |=> !blow_q)
    else $error("fast charge too long");
  chk_resistor_sel: assert property (##1 b900_q == $past(drv_q.rsel)) // RL8
    else $error("bias network does not follow select");

  sequence s_two_idle;
    (!tick || !use_div) ##1 (!tick || !use_div);
  endsequence

  chk_divide_three: assert property (use_div && div_q == 9'h003 && tick && $stable(div_q) // RL9
    |=> s_two_idle ##1 tick)
    else $error("divide by three wrong");
  chk_div_ignored: assert property (!div_ok |-> tick) // RL11
    else $error("divider active on wrong oscillator");
  chk_frame_wrap: assert property (disp_on && tick && frame_q == 9'h1ff // RL10
    |=> frame_q == 9'h000 ##1 (bp_q == 8'h01 || !on_q))
    else $error("frame not 512 display clocks");
  chk_active_onehot: assert property (on_q |-> $onehot(bp_q)) // RL16
    else $error("not exactly one backplane active");
  chk_port0_gate: assert property (!p0s_q[0] |=> !fp_q[16]) // RL12
    else $error("frontplane 17 driven while pin is io");
endmodule
`default_nettype wire

// >>> include/lcddc_pkg.sv
// lcd driver control: register map, field layout, types
package lcddc_pkg;
  // register word indices; byte address is four times the index
  localparam logic [9:0] IDX_DIV_HIGH = 10'h0aa;
  localparam logic [9:0] IDX_CONTROL = 10'h0ab;
  localparam logic [9:0] IDX_DIV_LOW = 10'h0ac;
  localparam logic [9:0] IDX_DRIVE = 10'h0ad;
  localparam logic [9:0] IDX_PORT0_SEL = 10'h0b6;
  localparam logic [9:0] IDX_MEM_FIRST = 10'h1e0;
  localparam logic [9:0] IDX_MEM_LAST = 10'h1f2;
  localparam int MEM_BYTES = 19;
  // display_control fields
  localparam int CTL_TYPE_SEL = 7;
  localparam int CTL_LCD_EN = 6;
  localparam int CTL_CONTRAST_EN = 5;
  localparam int CTL_DUTY = 4;
  localparam int CTL_LEVEL_LSB = 0;
  // lcd_drive_control fields
  localparam int DRV_RSEL = 4;
  localparam int DRV_FCT_LSB = 2;
  localparam int DRV_SCHEME_LSB = 0;
  localparam int P0S_WIDTH = 3;
  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [4:0] RST_DRIVE = 5'h00;
  localparam logic [8:0] RST_DIVIDER = 9'h000;
  localparam logic [2:0] RST_PORT0 = 3'h0;
  // oscillator options on which the divider takes effect
  localparam logic [3:0] OSC_INTERNAL_RC = 4'h0;
  localparam logic [3:0] OSC_CRYSTAL = 4'he;
  // frame timing, display clock periods
  localparam int FRAME_TICKS = 512;
  localparam logic [7:0] SLOT_TICKS_QUARTER = 8'h80;
  localparam logic [7:0] SLOT_TICKS_EIGHTH = 8'h40;
  localparam logic [1:0] FCT_BASE_SHIFT = 2'h3;
  localparam logic [3:0] LEVEL_FULL = 4'hf;
  localparam logic [3:0] LEVEL_ALIAS_FULL = 4'he;

  typedef enum logic [1:0] {
    LCDDC_TRAD_HIGH = 2'b00,
    LCDDC_TRAD_LOW = 2'b01,
    LCDDC_FAST = 2'b10,
    LCDDC_RESERVED = 2'b11
  } lcddc_scheme_e;

  typedef enum logic [2:0] {
    LCDDC_BUS_IDLE = 3'b001,
    LCDDC_BUS_WAIT = 3'b010,
    LCDDC_BUS_RESP = 3'b100
  } lcddc_bus_e;

  typedef struct packed {
    logic type_sel;
    logic lcd_en;
    logic contrast_en;
    logic duty8;
    logic [3:0] level;
  } lcddc_ctrl_s;

  typedef struct packed {
    logic rsel;
    logic [1:0] fct;
    lcddc_scheme_e scheme;
  } lcddc_drive_s;
endpackage

// >>> verif/lcd_driver_control_bench.sv
// self-checking bench for the lcd driver control core
`timescale 1ns/1ns
`default_nettype none
module lcd_driver_control_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] osc = 4'h0;
  logic pd = 1'b0;
  logic lfc = 1'b0;
  logic rdy, hresp, act, led, lows, hi9;
  logic [31:0] hrdata, rd;
  logic [7:0] bp;
  logic [18:0] fp, fp_at;
  logic [3:0] vlcd;
  logic [2:0] p0s;
  logic [7:0] mem [19];
  int n_mismatch = 0;
  int comparisons = 0;
  int seen, faults;
  always #2 clk = ~clk;
  lcddc_core dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(rdy), .hreadyout(rdy),
    .hrdata(hrdata), .hresp(hresp), .oscillator_option(osc), .power_down(pd),
    .low_freq_clock_run(lfc), .backplane(bp), .frontplane_line(fp), .lcd_active(act),
    .led_driver_select(led), .lcd_drive_voltage(vlcd), .bias_low_sum(lows),
    .bias_high_900k(hi9), .port0_segment_enable(p0s));
  lcddc_glass glass (.clk(clk), .backplane(bp), .frontplane_line(fp), .slots_seen(seen),
    .faults(faults));
  task report_and_stop;
    if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task check(input string what, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask
  // single word transfer, waits on hreadyout
  task ahb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task rdchk(input string what, input logic [9:0] idx, input logic [31:0] e);
    ahb(1'b0, idx, 32'h0);
    check(what, rd, e);
    check("hresp", hresp, 32'h0);
  endtask
  // length of the next whole slot showing pattern b
  task slot_len(input logic [7:0] b, output int n);
    n = 0;
    while (bp === b && n < 99999) begin @(posedge clk); n++; end
    n = 0;
    while (bp !== b && n < 99999) begin @(posedge clk); n++; end
    fp_at = fp;
    n = 0;
    while (bp === b && n < 99999) begin @(posedge clk); n++; end
  endtask
  task t_regs;
    logic [9:0] ix [5];
    logic [31:0] mk [5];
    ix = '{lcddc_pkg::IDX_DIV_HIGH, lcddc_pkg::IDX_CONTROL, lcddc_pkg::IDX_DIV_LOW,
      lcddc_pkg::IDX_DRIVE, lcddc_pkg::IDX_PORT0_SEL};
    mk = '{32'h01, 32'hff, 32'hff, 32'h1f, 32'h07};
    check("vlcd", vlcd, 32'hf);
    check("bp", bp, 32'h0);
    check("fp", fp, 32'h0);
    for (int i = 0; i < 5; i++) rdchk("reset", ix[i], 32'h0);
    for (int i = 0; i < 5; i++) begin
      ahb(1'b1, ix[i], 32'hffffffff);
      rdchk("mask", ix[i], mk[i]);
      ahb(1'b1, ix[i], 32'h0);
    end
    rdchk("unmapped", 10'h0a0, 32'h0);
  endtask
  task t_select;
    ahb(1'b1, lcddc_pkg::IDX_CONTROL, 32'h40);
    repeat (2) @(posedge clk);
    check("on", {led, act}, 32'h1);
    ahb(1'b1, lcddc_pkg::IDX_CONTROL, 32'hc0);
    repeat (2) @(posedge clk);
    check("led", {led, act, bp}, 32'h200);
    ahb(1'b1, lcddc_pkg::IDX_CONTROL, 32'h00);
    repeat (2) @(posedge clk);
    check("off", {act, bp}, 32'h0);
  endtask
  task t_contrast;
    for (int v = 0; v < 16; v++) begin
      ahb(1'b1, lcddc_pkg::IDX_CONTROL, 32'h20 | v);
      repeat (2) @(posedge clk);
      check("level", vlcd, v >= 14 ? 32'hf : v);
    end
    ahb(1'b1, lcddc_pkg::IDX_CONTROL, 32'h03);
    repeat (2) @(posedge clk);
    check("no contrast", vlcd, 32'hf);
  endtask
  task t_drive;
    int c;
    ahb(1'b1, lcddc_pkg::IDX_DRIVE, 32'h10);
    repeat (2) @(posedge clk);
    check("high sum", {hi9, lows}, 32'h2);
    ahb(1'b1, lcddc_pkg::IDX_DRIVE, 32'h01);
    repeat (2) @(posedge clk);
    check("60k sum", {hi9, lows}, 32'h1);
    ahb(1'b1, lcddc_pkg::IDX_DRIVE, 32'h03);
    repeat (2) @(posedge clk);
    check("reserved scheme", {hi9, lows}, 32'h0);
    ahb(1'b1, lcddc_pkg::IDX_CONTROL, 32'h40);
    for (int f = 0; f < 4; f++) begin
      ahb(1'b1, lcddc_pkg::IDX_DRIVE, 32'h02 | (f << 2));
      repeat (130) @(posedge clk);
      c = 0;
      repeat (128) begin @(posedge clk); c += int'(lows === 1'b1); end
      check("charge", c, 128 >> (3 + f));
    end
    ahb(1'b1, lcddc_pkg::IDX_DRIVE, 32'h0);
  endtask
  task t_frame(input logic d8);
    int n, len;
    logic [18:0] e;
    n = d8 ? 8 : 4;
    ahb(1'b1, lcddc_pkg::IDX_PORT0_SEL, 32'h5);
    ahb(1'b1, lcddc_pkg::IDX_CONTROL, d8 ? 32'h50 : 32'h40);
    check("p0", p0s, 32'h5);
    for (int k = 1; k <= n; k++) begin
      slot_len(8'h01 << (k % n), len);
      for (int i = 0; i < 19; i++) e[i] = mem[i][k % n] & (i < 16 || p0s[i - 16]);
      check("slot", len, 512 / n);
      check("seg", fp_at, e);
    end
  endtask
  task t_div;
    int len;
    logic [3:0] op [3];
    int ex [3];
    op = '{4'h0, 4'he, 4'h1};
    ex = '{384, 384, 128};
    ahb(1'b1, lcddc_pkg::IDX_DIV_LOW, 32'h3);
    ahb(1'b1, lcddc_pkg::IDX_CONTROL, 32'h40);
    for (int i = 0; i < 3; i++) begin
      osc <= op[i];
      slot_len(8'h02, len);
      slot_len(8'h02, len);
      check("divided", len, ex[i]);
    end
    osc <= 4'h0;
    ahb(1'b1, lcddc_pkg::IDX_DIV_LOW, 32'h0);
  endtask
  task t_power;
    int s0;
    pd <= 1'b1;
    lfc <= 1'b1;
    repeat (3) @(posedge clk);
    check("low clock", act, 32'h1);
    lfc <= 1'b0;
    repeat (3) @(posedge clk);
    s0 = seen;
    repeat (300) @(posedge clk);
    check("stopped", {act, bp, 23'(seen - s0)}, 32'h0);
    pd <= 1'b0;
    rdchk("kept", lcddc_pkg::IDX_MEM_LAST, mem[18]);
  endtask
  task t_reset;
    rstn <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    check("in reset", {act, bp, fp}, 32'h0);
    rstn <= 1'b1;
    @(posedge clk);
    rdchk("ctl", lcddc_pkg::IDX_CONTROL, 32'h0);
    rdchk("ram", lcddc_pkg::IDX_MEM_FIRST, mem[0]);
    check("glass", faults, 32'h0);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs;
    for (int i = 0; i < 19; i++) begin
      mem[i] = 8'(i * 29 + 7);
      ahb(1'b1, lcddc_pkg::IDX_MEM_FIRST + 10'(i), 32'(mem[i]));
    end
    rdchk("ram last", lcddc_pkg::IDX_MEM_LAST, mem[18]);
    t_select;
    t_contrast;
    t_drive;
    t_frame(1'b0);
    t_frame(1'b1);
    t_div;
    t_power;
    t_reset;
    report_and_stop;
  end
  initial begin
    #400000;
    n_mismatch++;
    report_and_stop;
  end
endmodule
`default_nettype wire

// >>> verif/lcddc_glass.sv
// glass model: counts backplane slots that light up
`timescale 1ns/1ns
`default_nettype none
module lcddc_glass (
  input wire logic clk,
  input wire logic [7:0] backplane,
  input wire logic [18:0] frontplane_line,
  output var int slots_seen,
  output var int faults
);
  logic [7:0] last_q = 8'h00;
  int slots_q = 0;
  int faults_q = 0;
  assign slots_seen = slots_q;
  assign faults = faults_q;
  always @(posedge clk) begin
    if (backplane !== last_q && backplane !== 8'h00) slots_q <= slots_q + 1;
    // one common at a time, dark segments with no common
    if ($countones(backplane) > 1 ||
        (backplane === 8'h00 && frontplane_line !== 19'h00000)) begin
      faults_q <= faults_q + 1;
    end
    last_q <= backplane;
  end
endmodule
`default_nettype wire
